// ### lpw_pkg.sv
// shared constants and types for the power-mode and wake sequencer
package lpw_pkg;
	// timing
	localparam int CLK_MHZ        = 50;
	localparam int RC_START_NS    = 60000;
	localparam int FLASH_START_NS = 100000;
	localparam int RC_START_CYC   = (RC_START_NS * CLK_MHZ + 999) / 1000;
	localparam int FLASH_CYC      = (FLASH_START_NS * CLK_MHZ + 999) / 1000;
	localparam int RC_WAKE_CYC    = 4;
	localparam int MAIN_WAKE_CYC  = 4096;
	localparam int CW             = 16;

	// wake sources
	localparam int NW      = 12;
	localparam int WK_NMI  = 0;
	localparam int WK_EXT0 = 1;
	localparam int WK_EXT3 = 4;
	localparam int WK_RTC  = 8;
	localparam int WK_WDT  = 11;

	// register byte offsets
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_STAT  = 4'h4;
	localparam logic [3:0] REG_CAUSE = 4'h8;
	localparam logic [3:0] REG_MASK  = 4'hC;

	// control fields
	localparam int CB_MODE   = 0;
	localparam int CB_OSC    = 2;
	localparam int CB_MAIN   = 3;
	localparam int CB_PLL    = 4;
	localparam int CB_LINK   = 5;
	localparam int CB_KEEP32 = 6;

	// status fields
	localparam int SB_FLASH = 0;
	localparam int SB_MAIN  = 1;
	localparam int SB_OSC   = 2;
	localparam int SB_LINK  = 3;
	localparam int SB_STATE = 4;

	localparam logic [1:0] MODE_SLEEP  = 2'h0;
	localparam logic [1:0] MODE_DSLEEP = 2'h1;
	localparam logic [1:0] MODE_PDOWN  = 2'h2;
	localparam logic [1:0] MODE_DPD    = 2'h3;

	// reset value of the packed output flops, order as in lpw_seq
	localparam logic [19:0] OUT_RST = 20'h3F816;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_ENTER,
		ST_SLEEP,
		ST_DSLEEP,
		ST_PDOWN,
		ST_DPD,
		ST_OSC,
		ST_RESUME
	} lpw_state_t;

	function automatic logic lpw_hit(input logic [NW-1:0] src,
			input logic [NW-1:0] mask);
		return |(src & mask);
	endfunction
endpackage

// ### lpw_cnt_if.sv
// load/done handshake between the sequencer and a delay counter
`timescale 1ns/100ps
`default_nettype none
interface lpw_cnt_if;
	import lpw_pkg::*;
	logic          load;
	logic [CW-1:0] value;
	logic          done;
	modport ctl (output load, output value, input done);
	modport tmr (input load, input value, output done);
endinterface
`default_nettype wire

// ### lpw_cnt.sv
// down-counter for oscillator, resume and flash wake delays
`timescale 1ns/100ps
`default_nettype none
module lpw_cnt
	import lpw_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	lpw_cnt_if.tmr    cif
);
	logic [CW-1:0] cnt;

	// done marks the last counted cycle, so a load of n spans n cycles
	assign cif.done = cnt == CW'(1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= '0;
		else if (cif.load)
			cnt <= cif.value;
		else if (cnt != '0)
			cnt <= cnt - CW'(1);
	end
endmodule
`default_nettype wire

// ### lpw_seq.sv
// power-mode and wake sequencer with avalon register slave
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Function
// - start and wake from power-down on the internal RC clock
// - offer sleep, deep-sleep, power-down and deep power-down
// - sleep gates the core clock; leaving re-enables it
// - sleep holds execution until reset or interrupt
// - sleep keeps DMA running, disables flash and main SRAM
// - any enabled interrupt ends sleep
// - deep-sleep stops clocks and holds pins static
// - deep-sleep gates RC output, keeps RC powered, RTC running
// - deep-sleep entry turns PLL off and clears dividers
// - flash stays powered in deep-sleep
// - listed enabled interrupt sources wake deep-sleep
// - deep-sleep resume after 4 RC or 4096 main cycles
// - power-down also powers off RC oscillator and flash
// - power-down entry: PLLs off, muxes reset, dividers cleared
// - running watchdog and enabled RTC continue in power-down
// - power-down wake waits RC start-up, then 4 RC cycles
// - flash timer blocks flash access for its start-up time
// - deep power-down only from RTC; only RTC stays powered
// - deep power-down option keeps or stops the 32 kHz oscillator
// - deep power-down wakes only by reset pin or RTC alarm
// - interrupt mask latched on entry; masked interrupt wakes
// - crystal used as clock only once it is stable
module lpw_seq
	import lpw_pkg::*;
#(
	parameter int FLASH_WAKE_CYC = FLASH_CYC,
	parameter int MAIN_CYC       = MAIN_WAKE_CYC,
	parameter int RC_ST_CYC      = RC_START_CYC,
	parameter int RC_CYC         = RC_WAKE_CYC
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic [3:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	output logic      [31:0]   avs_readdata,
	output logic               avs_waitrequest,
	input  wire logic          sleep_req,
	input  wire logic [NW-1:0] irq_mask,
	input  wire logic [NW-1:0] irq_src,
	input  wire logic          rtc_dpd_req,
	input  wire logic          rtc_alarm,
	input  wire logic          osc_stable,
	input  wire logic          wdt_running,
	output logic               sleep_ack,
	output logic               wake_evt,
	output logic               core_clk_en,
	output logic               sys_clk_en,
	output logic               flash_en,
	output logic               sram_en,
	output logic               dma_en,
	output logic               rc_out_en,
	output logic               rc_pwr_en,
	output logic               main_osc_en,
	output logic               clk_sel_main,
	output logic               pll_en,
	output logic               pll_link,
	output logic               div_clear,
	output logic               clksel_reset,
	output logic               flash_pwr_en,
	output logic               flash_ready,
	output logic               pin_hold,
	output logic               core_pwr_en,
	output logic               rtc_osc_en,
	output logic               wdt_osc_en
);
	localparam logic [CW-1:0] MAIN_CNT  = CW'(MAIN_CYC);
	localparam logic [CW-1:0] RC_CNT    = CW'(RC_CYC);
	localparam logic [CW-1:0] RC_ST     = CW'(RC_ST_CYC);
	localparam logic [CW-1:0] FLASH_CNT = CW'(FLASH_WAKE_CYC);
	localparam logic [NW-1:0] CAUSE_RTC = NW'(1) << WK_RTC;

	logic            rst_s1;
	logic            rst_n;
	lpw_state_t      state;
	lpw_state_t      next_state;
	logic [1:0]      tgt;
	logic [1:0]      mode_sel;
	logic            osc_on;
	logic            use_main;
	logic            pll_on;
	logic            pll_lnk;
	logic            keep32;
	logic [NW-1:0]   mask_lat;
	logic [NW-1:0]   cause;
	logic            src_lat;
	logic            fl_wait;
	logic [19:0]     out_q;
	logic            wk_load;
	logic [CW-1:0]   wk_val;
	logic [31:0]     ctrl_word;
	logic [31:0]     stat_word;

	lpw_cnt_if wk_if ();
	lpw_cnt_if fl_if ();

	lpw_cnt u_wk (
		.clk   (clk),
		.rst_n (rst_n),
		.cif   (wk_if)
	);

	lpw_cnt u_fl (
		.clk   (clk),
		.rst_n (rst_n),
		.cif   (fl_if)
	);

	// reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// wake decode
	wire hit_live = lpw_hit(irq_src, irq_mask);
	wire hit_lat  = lpw_hit(irq_src, mask_lat);
	wire lp_state = state == ST_SLEEP || state == ST_DSLEEP ||
		state == ST_PDOWN;
	wire [NW-1:0] mask_sel = (state == ST_DSLEEP || state == ST_PDOWN) ?
		mask_lat : irq_mask;
	wire cause_ld = next_state != state &&
		(lp_state || (state == ST_ENTER && hit_live));
	// software cannot select deep power-down on its own
	wire [1:0] next_tgt = rtc_dpd_req ? MODE_DPD :
		(mode_sel == MODE_DPD) ? MODE_SLEEP : mode_sel;
	wire ent_ds = state == ST_ENTER && next_state == ST_DSLEEP;
	wire ent_pd = state == ST_ENTER &&
		(next_state == ST_PDOWN || next_state == ST_DPD);
	wire fl_load = state == ST_OSC && wk_if.done;
	wire fl_set  = fl_wait && fl_if.done;
	wire next_flash_rdy = ent_pd ? 1'b0 : fl_set ? 1'b1 : flash_ready;

	assign wk_if.load  = wk_load;
	assign wk_if.value = wk_val;
	assign fl_if.load  = fl_load;
	assign fl_if.value = FLASH_CNT;

	// mode sequence
	always_comb begin
		next_state = state;
		wk_load    = 1'b0;
		wk_val     = '0;
		case (state)
		ST_RUN: begin
			if (rtc_dpd_req || sleep_req)
				next_state = ST_ENTER;
		end
		ST_ENTER: begin
			if (hit_live)
				next_state = ST_RUN;
			else if (tgt == MODE_SLEEP)
				next_state = ST_SLEEP;
			else if (tgt == MODE_DSLEEP)
				next_state = ST_DSLEEP;
			else if (tgt == MODE_PDOWN)
				next_state = ST_PDOWN;
			else
				next_state = ST_DPD;
		end
		ST_SLEEP: begin
			if (hit_live)
				next_state = ST_RUN;
		end
		ST_DSLEEP: begin
			if (hit_lat) begin
				next_state = ST_RESUME;
				wk_load    = 1'b1;
				wk_val     = src_lat ? MAIN_CNT : RC_CNT;
			end
		end
		ST_PDOWN: begin
			if (hit_lat) begin
				next_state = ST_OSC;
				wk_load    = 1'b1;
				wk_val     = RC_ST;
			end
		end
		ST_DPD: begin
			if (rtc_alarm) begin
				next_state = ST_OSC;
				wk_load    = 1'b1;
				wk_val     = RC_ST;
			end
		end
		ST_OSC: begin
			if (wk_if.done) begin
				next_state = ST_RESUME;
				wk_load    = 1'b1;
				wk_val     = RC_CNT;
			end
		end
		ST_RESUME: begin
			if (wk_if.done)
				next_state = ST_RUN;
		end
		default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
			tgt   <= MODE_SLEEP;
		end else begin
			state <= next_state;
			if (state == ST_RUN)
				tgt <= next_tgt;
		end
	end

	// mask from the interrupt controller, frozen for the stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_lat <= '0;
			src_lat  <= 1'b0;
		end else if (state == ST_RUN && next_state == ST_ENTER) begin
			mask_lat <= irq_mask;
			src_lat  <= clk_sel_main;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cause <= '0;
		else if (state == ST_DPD && rtc_alarm)
			cause <= CAUSE_RTC;
		else if (cause_ld)
			cause <= irq_src & mask_sel;
	end

	// flash stays blocked until its own start-up count ends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fl_wait     <= 1'b0;
			flash_ready <= 1'b1;
		end else begin
			// a new power-down drops a flash count still running
			fl_wait     <= fl_load | (fl_wait & ~fl_if.done & ~ent_pd);
			flash_ready <= next_flash_rdy;
		end
	end

	// register slave: one wait cycle, answer on the second edge
	wire req     = avs_read | avs_write;
	wire acc     = req & ~avs_waitrequest;
	wire wr_ctrl = acc & avs_write & (avs_address == REG_CTRL);
	wire [31:0] rd_word =
		(avs_address == REG_CTRL)  ? ctrl_word :
		(avs_address == REG_STAT)  ? stat_word :
		(avs_address == REG_CAUSE) ? 32'(cause) :
		(avs_address == REG_MASK)  ? 32'(mask_lat) : 32'h0;

	always_comb begin
		ctrl_word                  = 32'h0;
		ctrl_word[CB_MODE +: 2]    = mode_sel;
		ctrl_word[CB_OSC]          = osc_on;
		ctrl_word[CB_MAIN]         = use_main;
		ctrl_word[CB_PLL]          = pll_on;
		ctrl_word[CB_LINK]         = pll_lnk;
		ctrl_word[CB_KEEP32]       = keep32;
		stat_word                  = 32'h0;
		stat_word[SB_FLASH]        = flash_ready;
		stat_word[SB_MAIN]         = clk_sel_main;
		stat_word[SB_OSC]          = osc_stable;
		stat_word[SB_LINK]         = pll_link;
		stat_word[SB_STATE +: 3]   = state;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (req & avs_waitrequest)
				avs_readdata <= rd_word;
		end
	end

	// all clock options clear at reset, so the RC clock runs first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_sel <= MODE_SLEEP;
			osc_on   <= 1'b0;
			use_main <= 1'b0;
			pll_on   <= 1'b0;
			pll_lnk  <= 1'b0;
			keep32   <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				mode_sel <= avs_writedata[CB_MODE +: 2];
				osc_on   <= avs_writedata[CB_OSC];
				use_main <= avs_writedata[CB_MAIN];
				pll_on   <= avs_writedata[CB_PLL];
				pll_lnk  <= avs_writedata[CB_LINK];
				keep32   <= avs_writedata[CB_KEEP32];
			end
			if (ent_ds | ent_pd) begin
				pll_on  <= 1'b0;
				pll_lnk <= 1'b0;
			end
			if (ent_pd) begin
				use_main <= 1'b0;
				osc_on   <= 1'b0;
			end
		end
	end

	// outputs follow the next state so they change with it
	wire ns_on   = next_state == ST_RUN || next_state == ST_ENTER;
	wire ns_clk  = ns_on || next_state == ST_SLEEP;
	wire ns_dpd  = next_state == ST_DPD;
	wire ns_cold = next_state == ST_PDOWN || ns_dpd;
	wire ns_stop = ns_cold || next_state == ST_DSLEEP;
	wire n_ack   = state == ST_ENTER && next_state != ST_RUN;
	wire n_wake  = next_state == ST_RUN && state != ST_RUN;
	wire n_flash = ns_on & next_flash_rdy;
	wire n_ircout = !ns_stop && next_state != ST_OSC;
	wire n_main  = use_main & osc_on & osc_stable & ns_clk;
	wire n_pll   = pll_on & !ns_stop;
	wire n_link  = pll_lnk & pll_on & !ns_stop;
	wire n_rtc   = !ns_dpd | keep32;
	wire n_wdt   = wdt_running & !ns_dpd;
	wire [19:0] next_out = {
		n_ack, n_wake, ns_on, ns_clk, n_flash, ns_on, ns_clk,
		n_ircout, !ns_cold, osc_on & !ns_stop, n_main, n_pll, n_link,
		ent_ds | ent_pd, ent_pd, !ns_cold, ns_stop, !ns_dpd,
		n_rtc, n_wdt
	};

	assign {sleep_ack, wake_evt, core_clk_en, sys_clk_en, flash_en,
		sram_en, dma_en, rc_out_en, rc_pwr_en, main_osc_en,
		clk_sel_main, pll_en, pll_link, div_clear, clksel_reset,
		flash_pwr_en, pin_hold, core_pwr_en, rtc_osc_en,
		wdt_osc_en} = out_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			out_q <= OUT_RST;
		else
			out_q <= next_out;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_pd_rc_src: assert property (
		state == ST_PDOWN |-> !clk_sel_main && !use_main && !osc_on)
		else $error("main clock still selected in power-down");
	chk_sleep_core: assert property (
		state == ST_SLEEP |-> !core_clk_en && sys_clk_en)
		else $error("core clock not gated in sleep");
	chk_sleep_mem: assert property (
		state == ST_SLEEP |-> !flash_en && !sram_en && dma_en)
		else $error("memory or dma enables wrong in sleep");
	chk_sleep_wake: assert property (
		state == ST_SLEEP && hit_live |=> state == ST_RUN && wake_evt)
		else $error("sleep not left on enabled interrupt");
	chk_ds_clocks: assert property (
		state == ST_DSLEEP |-> !sys_clk_en && !rc_out_en && rc_pwr_en
			&& rtc_osc_en && pin_hold && flash_pwr_en)
		else $error("deep-sleep clock or power state wrong");
	chk_ds_entry: assert property (
		ent_ds |=> div_clear && !pll_en && !pll_link ##1 !pll_on)
		else $error("deep-sleep entry left pll or dividers");
	chk_ds_resume: assert property (
		state == ST_DSLEEP && hit_lat && !src_lat
			|=> (state == ST_RESUME) [*4] ##1 state == ST_RUN)
		else $error("rc resume from deep-sleep not 4 cycles");
	chk_pd_power: assert property (
		state == ST_PDOWN |-> !rc_pwr_en && !flash_pwr_en
			&& !main_osc_en && !sys_clk_en)
		else $error("power-down left oscillator or flash on");
	chk_pd_entry: assert property (
		ent_pd |=> clksel_reset && div_clear && !pll_en)
		else $error("power-down entry did not reset clocking");
	chk_wdt_keep: assert property (
		state == ST_PDOWN && wdt_running |=> wdt_osc_en)
		else $error("watchdog clock stopped in power-down");
	chk_flash_gate: assert property (
		fl_wait |-> !flash_en && !flash_ready)
		else $error("flash opened before its start-up count");
	chk_dpd_power: assert property (
		state == ST_DPD |-> !core_pwr_en && rtc_osc_en == keep32)
		else $error("deep power-down supply state wrong");
	chk_dpd_hold: assert property (
		state == ST_DPD && !rtc_alarm |=> state == ST_DPD)
		else $error("deep power-down left without alarm");
	chk_mask_latch: assert property (
		state == ST_RUN && next_state == ST_ENTER
			|=> mask_lat == $past(irq_mask))
		else $error("interrupt mask not latched on entry");
	chk_main_stable: assert property (
		clk_sel_main |-> $past(osc_stable))
		else $error("main clock selected while unstable");
	chk_entry_abort: assert property (
		state == ST_ENTER && hit_live
			|=> state == ST_RUN && wake_evt && !sleep_ack)
		else $error("entry not aborted on wake event");

	cov_sleep_trip: cover property (
		state == ST_SLEEP ##1 state == ST_RUN);
	cov_pd_wake: cover property (
		state == ST_OSC ##1 state == ST_RESUME);
	cov_abort: cover property (state == ST_ENTER && hit_live);
	cov_dpd_wake: cover property (state == ST_DPD && rtc_alarm);
endmodule
`default_nettype wire

// ### lpw_core_model.sv
// processor core and interrupt controller model facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module lpw_core_model
	import lpw_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          go,
	input  wire logic [NW-1:0] mask_cfg,
	input  wire logic          sleep_ack,
	input  wire logic          wake_evt,
	output logic               sleep_req,
	output logic [NW-1:0]      irq_mask
);
	// enabled lines of sufficient priority, offered continuously
	assign irq_mask = mask_cfg;
	// one request, held until entry is acknowledged or refused
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sleep_req <= 1'b0;
		else if (sleep_ack || wake_evt)
			sleep_req <= 1'b0;
		else if (go)
			sleep_req <= 1'b1;
	end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the power-mode and wake sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
	import lpw_pkg::*;
	localparam int IST  = 20;
	localparam int FLC  = 40;
	localparam int MNC  = 16;
	localparam int RWC  = RC_WAKE_CYC;
	localparam int CEIL = 20000;
	logic          clk = 1'b0;
	logic          resetn = 1'b0;
	logic [3:0]    avs_address = 4'h0;
	logic          avs_read = 1'b0;
	logic          avs_write = 1'b0;
	logic [31:0]   avs_writedata = 32'h0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic          sleep_req, go = 1'b0;
	logic [NW-1:0] irq_mask, mask_cfg = 12'h000, irq_src = 12'h000;
	logic          rtc_dpd_req = 1'b0, rtc_alarm = 1'b0;
	logic          osc_stable = 1'b0, wdt_running = 1'b0;
	logic          sleep_ack, wake_evt, core_clk_en, sys_clk_en;
	logic          flash_en, sram_en, dma_en, rc_out_en, rc_pwr_en;
	logic          main_osc_en, clk_sel_main, pll_en, pll_link;
	logic          div_clear, clksel_reset, flash_pwr_en, flash_ready;
	logic          pin_hold, core_pwr_en, rtc_osc_en, wdt_osc_en;
	logic          seen_div = 1'b0, seen_csr = 1'b0;
	logic [31:0]   q;
	int            err_total = 0, total_checks = 0, cycles = 0, n;
	logic          a;

	lpw_seq #(.FLASH_WAKE_CYC(FLC), .MAIN_CYC(MNC), .RC_ST_CYC(IST),
		.RC_CYC(RWC)) i_lpw_seq (.clk, .resetn, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .sleep_req, .irq_mask, .irq_src, .rtc_dpd_req,
		.rtc_alarm, .osc_stable, .wdt_running, .sleep_ack, .wake_evt,
		.core_clk_en, .sys_clk_en, .flash_en, .sram_en, .dma_en,
		.rc_out_en, .rc_pwr_en, .main_osc_en, .clk_sel_main, .pll_en,
		.pll_link, .div_clear, .clksel_reset, .flash_pwr_en, .flash_ready,
		.pin_hold, .core_pwr_en, .rtc_osc_en, .wdt_osc_en);
	lpw_core_model i_lpw_core_model (.clk, .rst_n(resetn), .go, .mask_cfg,
		.sleep_ack, .wake_evt, .sleep_req, .irq_mask);

	always #10 clk = ~clk;
	// entry pulses are short, so they are latched here for later checks
	always @(posedge clk) begin
		cycles++;
		if (div_clear === 1'b1)
			seen_div = 1'b1;
		if (clksel_reset === 1'b1)
			seen_csr = 1'b1;
		if (cycles >= CEIL) begin
			err_total++;
			conclude();
		end
	end

	task conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk_bit(input logic got, input logic exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp,
			input string m);
		chk_bit(got === exp, 1'b1, m);
	endtask
	task chk_cnt(input int got, input int lo, input int hi, input string m);
		chk_bit(got >= lo && got <= hi, 1'b1, m);
	endtask
	// avalon access: hold until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		avs_address <= ad;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// no local limit: a hung slave ends in the global timeout
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task enter(input logic rtc);
		@(posedge clk);
		if (rtc)
			rtc_dpd_req <= 1'b1;
		else
			go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sleep_ack !== 1'b1 && wake_evt !== 1'b1 && n < 10);
		a = (sleep_ack === 1'b1);
		rtc_dpd_req <= 1'b0;
		@(posedge clk);
	endtask
	task wait_wake(input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wake_evt !== 1'b1 && n < lim);
	endtask

	task t_reset();
		chk_bit(rc_out_en, 1'b1, "rc clock off at reset");
		chk_bit(clk_sel_main, 1'b0, "main clock at reset");
		chk_bit(pll_en, 1'b0, "pll on at reset");
		bus(1'b0, REG_CTRL, 32'h0);
		chk_word(q, 32'h0, "control reset value");
		bus(1'b0, 4'h2, 32'h0);
		chk_word(q, 32'h0, "unmapped read");
		bus(1'b1, REG_CTRL, 32'hFFFFFFFF);
		bus(1'b0, REG_CTRL, 32'h0);
		chk_word(q, 32'h0000007F, "control readback");
	endtask
	// mode 3 from software must give plain sleep
	task t_sleep();
		for (int m = 0; m < 4; m += 3) begin
			bus(1'b1, REG_CTRL, 32'(m));
			mask_cfg <= 12'h001;
			enter(1'b0);
			chk_bit(a, 1'b1, "sleep not acknowledged");
			chk_bit(core_clk_en, 1'b0, "core clock in sleep");
			chk_bit(core_pwr_en, 1'b1, "core power in sleep");
			chk_bit(sys_clk_en, 1'b1, "peripheral clock in sleep");
			chk_bit(dma_en, 1'b1, "dma in sleep");
			chk_bit(flash_en, 1'b0, "flash in sleep");
			chk_bit(sram_en, 1'b0, "sram in sleep");
			irq_src <= 12'h020;
			repeat (6) @(posedge clk);
			chk_bit(core_clk_en, 1'b0, "disabled line woke");
			mask_cfg <= 12'h021;
			wait_wake(8);
			chk_cnt(n, 2, 2, "sleep wake latency");
			chk_bit(core_clk_en, 1'b1, "core clock after sleep");
			irq_src <= 12'h000;
			mask_cfg <= 12'h000;
		end
	endtask
	// every listed source wakes deep-sleep through the latched mask
	task t_dsleep();
		bus(1'b1, REG_CTRL, 32'h31);
		for (int i = 0; i < NW; i++) begin
			mask_cfg <= NW'(1) << i;
			seen_div = 1'b0;
			enter(1'b0);
			mask_cfg <= 12'h000;
			chk_bit(a, 1'b1, "deep-sleep not acknowledged");
			chk_bit(sys_clk_en, 1'b0, "clock in deep-sleep");
			chk_bit(pin_hold, 1'b1, "pins not held");
			chk_bit(rc_out_en, 1'b0, "rc output in deep-sleep");
			chk_bit(rc_pwr_en, 1'b1, "rc power in deep-sleep");
			chk_bit(rtc_osc_en, 1'b1, "rtc osc in deep-sleep");
			chk_bit(pll_en | pll_link, 1'b0, "pll in deep-sleep");
			chk_bit(seen_div, 1'b1, "dividers not cleared");
			chk_bit(flash_pwr_en, 1'b1, "flash power in deep-sleep");
			bus(1'b0, REG_MASK, 32'h0);
			chk_word(q, 32'(NW'(1) << i), "latched mask");
			irq_src <= ~(NW'(1) << i);
			repeat (6) @(posedge clk);
			chk_bit(rc_out_en, 1'b0, "unmasked line woke");
			irq_src <= NW'(1) << i;
			wait_wake(20);
			chk_cnt(n, RWC + 2, RWC + 2, "rc resume");
			chk_bit(rc_out_en, 1'b1, "rc clock after wake");
			irq_src <= 12'h000;
			bus(1'b0, REG_CAUSE, 32'h0);
			chk_word(q, 32'(NW'(1) << i), "wake cause");
		end
	endtask
	task t_dmain();
		bus(1'b1, REG_CTRL, 32'h0D);
		repeat (4) @(posedge clk);
		chk_bit(main_osc_en, 1'b1, "main osc not enabled");
		chk_bit(clk_sel_main, 1'b0, "unstable crystal used");
		osc_stable <= 1'b1;
		repeat (4) @(posedge clk);
		chk_bit(clk_sel_main, 1'b1, "stable crystal unused");
		mask_cfg <= NW'(1) << WK_RTC;
		enter(1'b0);
		irq_src <= NW'(1) << WK_RTC;
		wait_wake(60);
		chk_cnt(n, MNC + 2, MNC + 2, "main clock resume");
		irq_src <= 12'h000;
	endtask
	task t_pdown();
		wdt_running <= 1'b1;
		bus(1'b1, REG_CTRL, 32'h1E);
		mask_cfg <= NW'(1) << WK_WDT;
		seen_div = 1'b0;
		seen_csr = 1'b0;
		enter(1'b0);
		chk_bit(rc_pwr_en | flash_pwr_en, 1'b0, "power-down power");
		chk_bit(main_osc_en, 1'b0, "main osc in power-down");
		chk_bit(pll_en, 1'b0, "pll in power-down");
		chk_bit(seen_csr & seen_div, 1'b1, "muxes or dividers kept");
		chk_bit(wdt_osc_en, 1'b1, "watchdog stopped");
		chk_bit(rtc_osc_en, 1'b1, "rtc stopped");
		chk_bit(flash_ready, 1'b0, "flash ready in power-down");
		irq_src <= NW'(1) << WK_WDT;
		wait_wake(80);
		chk_cnt(n, IST + RWC + 1, IST + RWC + 3, "pd wake");
		chk_bit(clk_sel_main, 1'b0, "power-down wake not on rc");
		chk_bit(flash_ready | flash_en, 1'b0, "early flash");
		irq_src <= 12'h000;
		wdt_running <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (flash_ready !== 1'b1 && n < FLC + 10);
		chk_cnt(n, FLC - RWC - 3, FLC, "flash timer");
		@(posedge clk);
		chk_bit(flash_en, 1'b1, "flash blocked after timer");
		bus(1'b0, REG_STAT, 32'h0);
		chk_word(q, 32'h00000005, "status after power-down");
	endtask
	task t_dpd(input logic keep);
		bus(1'b1, REG_CTRL, {25'h0, keep, 6'h00});
		mask_cfg <= NW'(1) << WK_RTC;
		enter(1'b1);
		chk_bit(core_pwr_en | rc_pwr_en, 1'b0, "core powered");
		chk_bit(rtc_osc_en, keep, "32k option");
		irq_src <= 12'h101;
		repeat (IST + 10) @(posedge clk);
		chk_bit(core_pwr_en, 1'b0, "irq left deep power-down");
		chk_bit(flash_ready, 1'b0, "flash ready in deep power-down");
		rtc_alarm <= 1'b1;
		wait_wake(80);
		chk_bit(wake_evt, 1'b1, "alarm did not wake");
		rtc_alarm <= 1'b0;
		irq_src <= 12'h000;
		bus(1'b0, REG_CAUSE, 32'h0);
		chk_word(q, 32'h00000100, "alarm cause");
	endtask
	task t_abort();
		bus(1'b1, REG_CTRL, 32'h01);
		mask_cfg <= 12'h002;
		irq_src <= 12'h002;
		enter(1'b0);
		chk_bit(a, 1'b0, "entry not aborted");
		repeat (6) @(posedge clk);
		irq_src <= 12'h000;
		repeat (4) @(posedge clk);
		chk_bit(core_clk_en, 1'b1, "not back in run");
	endtask

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_sleep();
		t_dsleep();
		t_dmain();
		t_pdown();
		t_dpd(1'b0);
		t_dpd(1'b1);
		t_abort();
		conclude();
	end
endmodule
`default_nettype wire
